/* hw/opms_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module opms_ctrl import opms_pkg::*; (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Classic Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Control pins.
  input wire logic standby_pin,
  input wire logic [1:0] direct_input_pins,
  // Supply comparator flags.
  input wire logic vs_le_3v0,
  input wire logic vs_le_op,
  input wire logic vdd_le_uv,
  input wire logic vdd_le_lop,
  // Mode, channel drive and capability outputs.
  output logic [1:0] op_mode,
  output logic [7:0] channel_drive,
  output logic serial_regs_reset,
  output logic serial_comm_en,
  output logic serial_write_en,
  output logic serial_out_hiz,
  output logic sclk_fast_ok,
  output logic limp_home_avail
);

  opms_state_t s_q; // Registered state.
  opms_state_t s_d; // Next state.
  opms_pins_t pin_s; // Synchronised pins.
  opms_supply_t sup_s; // Synchronised supply flags.
  logic [6:0] sync_out; // Synchroniser output bundle.

  opms_sync #(.W(7), .RST_VAL(SYNC_RST)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_i({standby_pin, direct_input_pins, vs_le_3v0, vs_le_op, vdd_le_uv, vdd_le_lop}),
    .sync_o(sync_out)
  );
  assign pin_s = opms_pins_t'(sync_out[6:4]);
  assign sup_s = opms_supply_t'(sync_out[3:0]);

  // Next-state logic for mode, registers, drive and bus.
  always_comb begin
    logic any_in;
    logic limp_ok;
    logic regs_rst;
    logic wake_req;
    logic band;
    logic [7:0] req;
    opms_mode_t mode_n;
    // Every local starts from a known value so no path leaves a latch.
    limp_ok = 1'b0;
    regs_rst = 1'b0;
    req = 8'h00;
    mode_n = OPMS_SLEEP;
    s_d = s_q;
    any_in = |pin_s.direct_input_pins;
    wake_req = 1'b0;
    band = sup_s.vs_le_op && !sup_s.vs_le_3v0;
    // Power-up needs a pin high and one supply operating.
    if (s_q.pwr) begin
      s_d.pwr = pin_s.standby || any_in;
    end else begin
      s_d.pwr = (pin_s.standby || any_in) && (!sup_s.vs_le_op || !sup_s.vdd_le_lop);
    end
    // Limp home lost without power or at low analog and digital undervoltage.
    limp_ok = s_d.pwr && !(sup_s.vs_le_3v0 && sup_s.vdd_le_uv);
    // Mode chosen from pins and bits.
    if (!s_d.pwr) begin
      mode_n = OPMS_SLEEP;
    end else if (!pin_s.standby) begin
      mode_n = (any_in && limp_ok) ? OPMS_LIMP : OPMS_SLEEP;
    end else if (any_in || (|s_q.channel_on_bits)
                 || (s_q.keep_active_bit && s_q.mode == OPMS_ACTIVE)) begin
      mode_n = OPMS_ACTIVE;
    end else begin
      mode_n = OPMS_IDLE;
    end
    // Leaving sleep or idle for a driving mode starts the latency.
    case (s_q.mode)
      OPMS_SLEEP, OPMS_IDLE: begin
        wake_req = (mode_n == OPMS_ACTIVE) || (mode_n == OPMS_LIMP);
      end
      OPMS_ACTIVE, OPMS_LIMP: begin
        wake_req = 1'b0;
      end
      default: begin
        mode_n = OPMS_SLEEP;
      end
    endcase
    s_d.mode = mode_n;
    if (wake_req) begin
      s_d.wake = TRANS_LAT_CYC;
    end else if (s_q.wake != 6'h00) begin
      s_d.wake = s_q.wake - 6'h01;
    end
    // Registers reset in sleep, limp home or digital undervoltage.
    regs_rst = (mode_n == OPMS_SLEEP) || (mode_n == OPMS_LIMP) || sup_s.vdd_le_uv;
    s_d.caps.serial_regs_reset = regs_rst;
    s_d.caps.serial_comm_en = !sup_s.vdd_le_uv && mode_n != OPMS_SLEEP;
    s_d.caps.serial_write_en = s_d.caps.serial_comm_en && mode_n != OPMS_LIMP;
    s_d.caps.serial_out_hiz = !s_d.caps.serial_comm_en;
    // Fast serial clock only outside the low-supply corner.
    s_d.caps.sclk_fast_ok = s_d.caps.serial_comm_en && !(sup_s.vdd_le_lop && sup_s.vs_le_op);
    s_d.caps.limp_home_avail = limp_ok;
    // Bus handshake: one ack per request, dropped the cycle after.
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
    s_d.dat = 32'h0000_0000;
    if (regs_rst) begin
      s_d.channel_on_bits = CHAN_BITS_RST;
      s_d.keep_active_bit = 1'b0;
    end else if (s_d.ack && wb_we_i && wb_adr_i == REG_CTRL_OFS && s_q.caps.serial_write_en) begin
      // Serial writes accepted only when serial_write_en was already set in the cycle before.
      if (wb_sel_i[0]) begin
        s_d.channel_on_bits = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        s_d.keep_active_bit = wb_dat_i[CTRL_KEEP_POS];
      end
    end
    // Read data; unmapped offsets read zero.
    if (s_d.ack && !wb_we_i) begin
      if (wb_adr_i == REG_CTRL_OFS) begin
        s_d.dat[7:0] = s_q.channel_on_bits;
        s_d.dat[CTRL_KEEP_POS] = s_q.keep_active_bit;
      end else if (wb_adr_i == REG_STATUS_OFS) begin
        s_d.dat[1:0] = s_q.mode;
        s_d.dat[STAT_FLAGS_POS +: 6] = s_q.caps;
        s_d.dat[STAT_FLAGS_POS + 6] = s_q.pwr;
        s_d.dat[STAT_DRIVE_POS +: 8] = s_q.drive;
      end
    end
    // Pins drive their default channels; serial bits only in active.
    req = (pin_s.direct_input_pins[0] ? IN0_CHAN_MAP : 8'h00)
        | (pin_s.direct_input_pins[1] ? IN1_CHAN_MAP : 8'h00);
    if (mode_n == OPMS_ACTIVE && !sup_s.vdd_le_uv) begin
      req = req | s_d.channel_on_bits;
    end
    if ((mode_n != OPMS_ACTIVE && mode_n != OPMS_LIMP) || s_d.wake != 6'h00) begin
      req = 8'h00;
    end
    // In the mid analog band only channels already on may stay on.
    s_d.drive = band ? (req & s_q.drive) : req;
  end

  // State register.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.mode <= OPMS_SLEEP;
      s_q.caps.serial_regs_reset <= 1'b1;
      s_q.caps.serial_out_hiz <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register.
  assign op_mode = s_q.mode;
  assign channel_drive = s_q.drive;
  assign serial_regs_reset = s_q.caps.serial_regs_reset;
  assign serial_comm_en = s_q.caps.serial_comm_en;
  assign serial_write_en = s_q.caps.serial_write_en;
  assign serial_out_hiz = s_q.caps.serial_out_hiz;
  assign sclk_fast_ok = s_q.caps.sclk_fast_ok;
  assign limp_home_avail = s_q.caps.limp_home_avail;
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.dat;

  // Checks on the mode machine and gating.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_sleep_off;
    s_q.mode == OPMS_SLEEP |-> channel_drive == 8'h00 && serial_out_hiz && serial_regs_reset;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("Sleep with output or serial on.");

  property p_enter_active;
    s_q.pwr && pin_s.standby && (|pin_s.direct_input_pins) |=> s_q.mode == OPMS_ACTIVE;
  endproperty
  a_enter_active: assert property (p_enter_active) else $error("Active not entered.");

  property p_back_idle;
    s_q.pwr && pin_s.standby && !(|pin_s.direct_input_pins) && s_q.channel_on_bits == 8'h00
      && !s_q.keep_active_bit |=> s_q.mode == OPMS_IDLE;
  endproperty
  a_back_idle: assert property (p_back_idle) else $error("Idle not reached.");

  property p_keep;
    s_q.mode == OPMS_ACTIVE && s_q.keep_active_bit && s_q.pwr && pin_s.standby
      |=> s_q.mode == OPMS_ACTIVE;
  endproperty
  a_keep: assert property (p_keep) else $error("Keep-active did not hold.");

  property p_limp_ro;
    s_q.mode == OPMS_LIMP |-> !serial_write_en && serial_regs_reset;
  endproperty
  a_limp_ro: assert property (p_limp_ro) else $error("Write allowed in limp home.");

  property p_vdd_uv;
    sup_s.vdd_le_uv |=> !serial_comm_en && s_q.channel_on_bits == 8'h00;
  endproperty
  a_vdd_uv: assert property (p_vdd_uv) else $error("Serial alive in undervoltage.");

  property p_latency;
    s_q.mode == OPMS_IDLE ##1 s_q.mode == OPMS_ACTIVE |-> channel_drive == 8'h00 [*8];
  endproperty
  a_latency: assert property (p_latency) else $error("Turn-on before latency.");

  property p_limp_avail;
    sup_s.vs_le_3v0 && sup_s.vdd_le_uv |=> !limp_home_avail && s_q.mode != OPMS_LIMP;
  endproperty
  a_limp_avail: assert property (p_limp_avail) else $error("Limp home when unavailable.");

  property p_nopwr;
    !s_q.pwr |-> !serial_comm_en && channel_drive == 8'h00 && !limp_home_avail;
  endproperty
  a_nopwr: assert property (p_nopwr) else $error("Capability before power-up.");

  property p_band;
    sup_s.vs_le_op && !sup_s.vs_le_3v0 |=> (channel_drive & ~$past(channel_drive)) == 8'h00;
  endproperty
  a_band: assert property (p_band) else $error("New turn-on in supply band.");

  property p_sclk;
    sup_s.vdd_le_lop && sup_s.vs_le_op |=> !sclk_fast_ok;
  endproperty
  a_sclk: assert property (p_sclk) else $error("Fast clock in low supply.");

  c_active: cover property (s_q.mode == OPMS_IDLE ##1 s_q.mode == OPMS_ACTIVE);
  c_limp: cover property (s_q.mode == OPMS_LIMP && channel_drive != 8'h00);
  c_sleep: cover property (s_q.mode == OPMS_ACTIVE ##[1:50] s_q.mode == OPMS_SLEEP);

endmodule
`default_nettype wire

/* hw/opms_pkg.sv */
package opms_pkg;

  // Clock period and the mode transition latency.
  localparam int CLK_PERIOD_NS = 40;
  localparam int TRANS_LAT_NS = 1000;
  localparam int TRANS_LAT_CYC_I = (TRANS_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] TRANS_LAT_CYC = 6'(TRANS_LAT_CYC_I);

  // Register byte offsets on the bus.
  localparam logic [3:0] REG_CTRL_OFS = 4'h0;
  localparam logic [3:0] REG_STATUS_OFS = 4'h4;

  // Field positions in the control and status words.
  localparam int CTRL_KEEP_POS = 8;
  localparam int STAT_FLAGS_POS = 2;
  localparam int STAT_DRIVE_POS = 16;

  // Reset values.
  localparam logic [7:0] CHAN_BITS_RST = 8'h00;
  localparam logic [6:0] SYNC_RST = 7'h0f;

  // Default channels tied to each direct input pin.
  localparam logic [7:0] IN0_CHAN_MAP = 8'h04;
  localparam logic [7:0] IN1_CHAN_MAP = 8'h08;

  // Operating modes with their binary codes.
  typedef enum logic [1:0] {
    OPMS_SLEEP = 2'b00,
    OPMS_LIMP = 2'b01,
    OPMS_ACTIVE = 2'b10,
    OPMS_IDLE = 2'b11
  } opms_mode_t;

  // Control pin levels.
  typedef struct packed {
    logic standby;
    logic [1:0] direct_input_pins;
  } opms_pins_t;

  // Supply comparator flags, each high when the supply is at or below the level.
  typedef struct packed {
    logic vs_le_3v0;
    logic vs_le_op;
    logic vdd_le_uv;
    logic vdd_le_lop;
  } opms_supply_t;

  // Capability outputs granted to the rest of the device.
  typedef struct packed {
    logic serial_regs_reset;
    logic serial_comm_en;
    logic serial_write_en;
    logic serial_out_hiz;
    logic sclk_fast_ok;
    logic limp_home_avail;
  } opms_caps_t;

  // Whole state of the controller.
  typedef struct packed {
    opms_mode_t mode;
    logic pwr;
    logic [5:0] wake;
    logic [7:0] channel_on_bits;
    logic keep_active_bit;
    logic [7:0] drive;
    opms_caps_t caps;
    logic ack;
    logic [31:0] dat;
  } opms_state_t;

endpackage

/* hw/opms_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// Two-stage synchroniser; the first stage feeds only the second.
module opms_sync import opms_pkg::*; #(
  parameter int W = 7,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Raw and synchronised levels.
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  genvar i;
  // One flop pair per bit.
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      logic stab_q;
      // The first flop is read only by the second.
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          meta_q <= RST_VAL[i];
          stab_q <= RST_VAL[i];
        end else begin
          meta_q <= async_i[i];
          stab_q <= meta_q;
        end
      end
      assign sync_o[i] = stab_q;
    end
  endgenerate

endmodule
`default_nettype wire

/* test/opms_ctrl_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the operation mode controller.
module opms_ctrl_tb_top import opms_pkg::*;;
  logic clk_sys, rst, cyc, stb, we, ack;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, rd;
  opms_pins_t pins_q;
  opms_supply_t sup_q;
  logic [1:0] op_mode;
  logic [7:0] channel_drive;
  logic regs_rst, comm_en, write_en, out_hiz, sclk_fast, limp_avail;
  logic [5:0] caps;
  int failures, num_checks;
  assign caps = {regs_rst, comm_en, write_en, out_hiz, sclk_fast, limp_avail};
  // The clock toggles every half period of 20 ns.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  opms_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .standby_pin(pins_q.standby),
    .direct_input_pins(pins_q.direct_input_pins), .vs_le_3v0(sup_q.vs_le_3v0),
    .vs_le_op(sup_q.vs_le_op), .vdd_le_uv(sup_q.vdd_le_uv), .vdd_le_lop(sup_q.vdd_le_lop),
    .op_mode(op_mode), .channel_drive(channel_drive), .serial_regs_reset(regs_rst),
    .serial_comm_en(comm_en), .serial_write_en(write_en), .serial_out_hiz(out_hiz),
    .sclk_fast_ok(sclk_fast), .limp_home_avail(limp_avail));
  opms_host host_u (.clk_sys(clk_sys), .sclk_fast_ok(sclk_fast), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat),
    .wb_dat_i(rdat), .wb_ack_i(ack));
  // Verdict and end of run.
  task automatic end_of_test();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus cycle through the host; a lost answer ends the run.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic ok;
    host_u.xfer(w, a, d, 4'h3, rd, ok);
    if (!ok) begin
      failures++;
      end_of_test();
    end
  endtask
  // Sets pins and supplies, then waits n clock cycles.
  task automatic setin(input logic [2:0] p, input logic [3:0] s, input int n);
    @(posedge clk_sys);
    pins_q <= p;
    sup_q <= s;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic t_reset();
    chk(32'({op_mode, channel_drive, caps}), 32'h0000_0024);
    $display("test reset done");
  endtask
  task automatic t_active();
    setin(3'h5, 4'h0, 20);
    chk(32'({op_mode, channel_drive}), 32'h0000_0200);
    setin(3'h5, 4'h0, 12);
    chk(32'({op_mode, channel_drive}), 32'h0000_0204);
    chk(32'(caps), 32'h0000_001b);
    $display("test active done");
  endtask
  task automatic t_serial();
    bus(1'b1, 4'h0, 32'h0000_0081);
    setin(3'h5, 4'h0, 32);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk(rd, 32'h0085_016e);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(rd, 32'h0000_0081);
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test serial done");
  endtask
  task automatic t_idle();
    setin(3'h4, 4'h0, 32);
    chk(32'(op_mode), 32'h0000_0002);
    bus(1'b1, 4'h0, 32'h0000_0000);
    setin(3'h4, 4'h0, 32);
    chk(32'({op_mode, channel_drive}), 32'h0000_0300);
    bus(1'b1, 4'h0, 32'h0000_0101);
    bus(1'b1, 4'h0, 32'h0000_0100);
    setin(3'h4, 4'h0, 32);
    chk(32'({op_mode, channel_drive}), 32'h0000_0200);
    $display("test idle done");
  endtask
  task automatic t_band();
    bus(1'b1, 4'h0, 32'h0000_0001);
    setin(3'h4, 4'h4, 32);
    bus(1'b1, 4'h0, 32'h0000_0003);
    setin(3'h4, 4'h4, 32);
    chk(32'({channel_drive, sclk_fast}), 32'h0000_0003);
    setin(3'h4, 4'h5, 4);
    chk(32'(sclk_fast), 32'h0000_0000);
    chk(32'(host_u.sclk_mhz), 32'h0000_0001);
    $display("test band done");
  endtask
  task automatic t_uv();
    setin(3'h4, 4'hf, 8);
    chk(32'({regs_rst, comm_en, limp_avail}), 32'h0000_0004);
    setin(3'h4, 4'h3, 8);
    chk(32'(limp_avail), 32'h0000_0001);
    setin(3'h4, 4'h0, 8);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test uv done");
  endtask
  task automatic t_limp();
    setin(3'h2, 4'h0, 32);
    chk(32'({op_mode, channel_drive, comm_en, write_en}), 32'h0000_0422);
    bus(1'b1, 4'h0, 32'h0000_0001);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test limp done");
  endtask
  task automatic t_sleep();
    setin(3'h0, 4'h0, 32);
    chk(32'({op_mode, channel_drive, regs_rst, out_hiz}), 32'h0000_0003);
    $display("test sleep done");
  endtask
  // Main sequence: reset for five cycles, then every scenario in turn.
  initial begin
    rst = 1'b1;
    failures = 0;
    num_checks = 0;
    pins_q = 3'h0;
    sup_q = 4'hf;
    host_u.idle_bus();
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_active();
    t_serial();
    t_idle();
    t_band();
    t_uv();
    t_limp();
    t_sleep();
    end_of_test();
  end
endmodule
`default_nettype wire

/* test/opms_host.sv */
`timescale 1ns/1ns
`default_nettype none
// Host model: a classic Wishbone master that holds each request until ack, for at most 16 cycles.
module opms_host (
  // Clock and the speed grant.
  input wire logic clk_sys,
  input wire logic sclk_fast_ok,
  // Wishbone master side.
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [3:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  // serial clock limit
  // The host picks its serial clock in MHz from the grant.
  logic [2:0] sclk_mhz;
  assign sclk_mhz = sclk_fast_ok ? 3'h5 : 3'h1;
  // Puts the bus in its idle state before the first clock edge.
  // It runs in the caller's process, so the bus has a single driver.
  task automatic idle_bus();
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 4'h0;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
  endtask
  // One bus cycle; ok stays low if no ack comes within the bound.
  task automatic xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                      input logic [3:0] sel, output logic [31:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h0000_0000;
    @(posedge clk_sys);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= sel;
    wb_dat_o <= wd;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge clk_sys);
      if (wb_ack_i === 1'b1) begin
        ok = 1'b1;
        rd = wb_dat_i;
      end
    end
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    // Released data is inverted so stale data never looks valid.
    wb_dat_o <= ~wd;
  endtask
endmodule
`default_nettype wire
